//--- shared/dshi_if.sv
// pins between the host controller and the sensing device
`timescale 1ns/1ps
`default_nettype none
interface dshi_if;
  logic interface_select;
  logic select_or_address_pin;
  logic sclk;
  logic mosi;
  logic miso;
  logic scl;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;
  // open drain with pull-up: any enabled low driver wins
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
  modport dev (input interface_select, select_or_address_pin, sclk, mosi, scl, sda,
               output miso, sda_d_o, sda_d_oe);
  modport host (output interface_select, select_or_address_pin, sclk, mosi, scl, sda_h_o, sda_h_oe,
                input miso, sda);
endinterface
`default_nettype wire

//--- shared/dshi_pkg.sv
// shared constants and types of the dual serial host interface
package dshi_pkg;
  localparam int         CLK_NS         = 40;
  localparam int         SPI_PERIOD_NS  = 640;
  localparam int         I2C_PERIOD_NS  = 2500;
  localparam int         SPI_HALF       = (SPI_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int         I2C_QUARTER    = (I2C_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam logic [4:0] SPI_RD_EDGE    = 5'h10;
  localparam logic [4:0] SPI_WR_EDGE    = 5'h18;
  localparam logic [4:0] SPI_WORD_LAST  = 5'h17;
  localparam logic [4:0] SPI_BYTE_LAST  = 5'h07;
  localparam logic [7:0] SPI_CMD_RD     = 8'h80;
  localparam logic [7:0] SPI_CMD_WR     = 8'h00;
  localparam logic [5:0] I2C_ADDR_HI    = 6'h32;
  localparam logic [3:0] I2C_LAST_BIT   = 4'h7;
  localparam logic [3:0] I2C_ACK_BIT    = 4'h8;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [7:0] QUEUE_PORT     = 8'h08;
  localparam logic [1:0] RETRY_MAX      = 2'h3;
  typedef enum logic [2:0] {OP_SPI_WR, OP_SPI_RD, OP_SPI_BURST, OP_I2C_WR, OP_I2C_RD} dshi_op_t;
endpackage

//--- test/dshi_chk.sv
// wire-level checks on the link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module dshi_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic interface_select,
  input wire logic select_or_address_pin,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic scl,
  input wire logic sda_h_o,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic sda
);
  logic [2:0] spi_age_q;
  logic [7:0] rise_cnt_q;
  logic       sclk_q;
  logic       scl_q;
  logic       sda_q;
  // mode switches reset the idle engine, so settle before judging
  wire        spi_on = spi_age_q == 3'h7;
  wire        frame_ok = rise_cnt_q == 8'h18 || (rise_cnt_q >= 8'h28 && (rise_cnt_q - 8'h10) % 8'h18 == 8'h00);
  wire        start_w = scl && scl_q && sda_q && !sda;
  wire        stop_w = scl && scl_q && !sda_q && sda;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) spi_age_q <= 3'h0;
    else if (interface_select) spi_age_q <= 3'h0;
    else if (!spi_on) spi_age_q <= spi_age_q + 3'h1;
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) rise_cnt_q <= 8'h00;
    else if (select_or_address_pin) rise_cnt_q <= 8'h00;
    else if (sclk && !sclk_q) rise_cnt_q <= rise_cnt_q + 8'h01;
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclk_q <= 1'b0;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      sclk_q <= sclk;
      scl_q  <= scl;
      sda_q  <= sda;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_start;
    start_w;
  endsequence
  sequence s_low_soon;
    ##[1:40] !scl;
  endsequence
  a_miso_quiet: assert property (interface_select [*4] |-> !miso)
    else $error("data out active in two-wire mode");
  a_sda_spi_mode: assert property (!interface_select [*4] |-> !sda_d_oe)
    else $error("data line pulled in four-wire mode");
  a_open_drain: assert property (!sda_d_o && !sda_h_o)
    else $error("open drain output drives high");
  a_miso_on_fall: assert property (spi_on && !select_or_address_pin && $changed(miso) |-> !sclk)
    else $error("data out changed while clock high");
  a_mosi_on_fall: assert property (spi_on && !select_or_address_pin && $changed(mosi) |-> !sclk)
    else $error("data in changed while clock high");
  a_sclk_framed: assert property (spi_on && select_or_address_pin |-> !sclk)
    else $error("serial clock outside frame");
  a_frame_length: assert property (spi_on && $rose(select_or_address_pin) && rise_cnt_q != 8'h00 |-> frame_ok)
    else $error("frame length not 24 or 16 plus words");
  a_start_pulse: assert property (s_start |-> s_low_soon)
    else $error("clock high pulse after start too long");
  a_stop_apart: assert property (s_start |=> !stop_w until !scl)
    else $error("stop in same high pulse as start");
endmodule
`default_nettype wire

//--- test/dual_serial_host_interface_bench.sv
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module dual_serial_host_interface_bench;
  import dshi_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        cmd_valid = 1'b0;
  dshi_op_t    cmd_op = OP_SPI_WR;
  logic [7:0]  cmd_addr = 8'h00;
  logic [7:0]  cmd_data = 8'h00;
  logic [7:0]  cmd_count = 8'h01;
  logic        addr_bit = 1'b1;
  logic        cmd_ready, rsp_valid, done, err, reg_wr, reg_rd, q_ready;
  logic [23:0] rsp_data;
  logic [7:0]  reg_addr, reg_wdata;
  logic [7:0]  regs [256];
  logic [23:0] words [4];
  logic [23:0] rsp_q [$];
  int          qi = 0;
  int          qn = 0;
  int          wr_n = 0;
  int          failures = 0;
  int          checked = 0;
  wire logic        q_valid = qi < qn;
  wire logic [23:0] q_data = words[qi[1:0]];
  wire logic [7:0]  reg_rdata = regs[reg_addr];
  always #20 mclk = ~mclk;
  // register file and queue source standing in for the device core
  always @(posedge mclk) begin
    if (reg_wr === 1'b1) begin
      regs[reg_addr] <= reg_wdata;
      wr_n <= wr_n + 1;
    end
    if (q_valid && q_ready === 1'b1) qi <= qi + 1;
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
  end
  dshi_if u_dshi_if ();
  dshi_host u_dshi_host (.mclk, .reset, .bus(u_dshi_if), .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_count,
    .addr_bit, .cmd_ready, .rsp_valid, .rsp_data, .done, .err);
  dshi_device u_dshi_device (.mclk, .reset, .bus(u_dshi_if), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .q_valid, .q_data, .q_ready);
  dshi_chk u_dshi_chk (.mclk, .reset, .interface_select(u_dshi_if.interface_select),
    .select_or_address_pin(u_dshi_if.select_or_address_pin), .sclk(u_dshi_if.sclk), .mosi(u_dshi_if.mosi),
    .miso(u_dshi_if.miso), .scl(u_dshi_if.scl), .sda_h_o(u_dshi_if.sda_h_o), .sda_d_o(u_dshi_if.sda_d_o),
    .sda_d_oe(u_dshi_if.sda_d_oe), .sda(u_dshi_if.sda));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // fields held until done, since two-wire frames re-read them
  task automatic run(input dshi_op_t op, input logic [7:0] a, input logic [7:0] d, input logic [7:0] n,
                     input logic b);
    int k;
    rsp_q.delete();
    @(posedge mclk);
    cmd_op    <= op;
    cmd_addr  <= a;
    cmd_data  <= d;
    cmd_count <= n;
    addr_bit  <= b;
    cmd_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 20000);
    cmd_valid <= 1'b0;
    do begin
      @(posedge mclk);
      k++;
    end while (done !== 1'b1 && k < 20000);
    if (k >= 20000) begin
      failures++;
      end_sim;
    end
    @(posedge mclk);
    chk(err, 1'b0);
  endtask
  task automatic t_spi;
    int w0;
    w0 = wr_n;
    run(OP_SPI_WR, 8'h12, 8'h5a, 8'h01, 1'b1);
    chk(regs[8'h12], 8'h5a);
    chk(24'(wr_n - w0), 24'h1);
    run(OP_SPI_RD, 8'h12, 8'h00, 8'h01, 1'b1);
    chk(rsp_q[0][7:0], 8'h5a);
    run(OP_SPI_RD, 8'h21, 8'h00, 8'h01, 1'b1);
    chk(rsp_q[0][7:0], 8'h21 ^ 8'h3c);
    $display("test spi single done");
  endtask
  task automatic t_burst;
    words[0] = 24'h1abcde;
    words[1] = 24'h2f0123;
    words[2] = 24'h345678;
    @(posedge mclk);
    qn <= 3;
    repeat (8) @(posedge mclk);
    chk(q_ready, 1'b0);
    chk(24'(qi), 24'h2);
    run(OP_SPI_BURST, QUEUE_PORT, 8'h00, 8'h04, 1'b1);
    for (int i = 0; i < 3; i++) chk(rsp_q[i], words[i]);
    chk(rsp_q[3], 24'h0);
    $display("test queue burst done");
  endtask
  task automatic t_i2c;
    run(OP_I2C_WR, 8'h30, 8'h77, 8'h01, 1'b0);
    chk(regs[8'h30], 8'h77);
    run(OP_I2C_WR, 8'h31, 8'h66, 8'h01, 1'b1);
    chk(regs[8'h31], 8'h66);
    run(OP_I2C_RD, 8'h30, 8'h00, 8'h03, 1'b0);
    chk({rsp_q[0][7:0], rsp_q[1][7:0], rsp_q[2][7:0]}, {16'h7766, 8'h32 ^ 8'h3c});
    run(OP_I2C_RD, QUEUE_PORT, 8'h00, 8'h02, 1'b1);
    chk({rsp_q[0][7:0], rsp_q[1][7:0]}, {2{8'h08 ^ 8'h3c}});
    run(OP_SPI_RD, 8'h31, 8'h00, 8'h01, 1'b1);
    chk(rsp_q[0][7:0], 8'h66);
    $display("test two-wire done");
  endtask
  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h3c;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_spi;
    t_burst;
    t_i2c;
    end_sim;
  end
endmodule
`default_nettype wire

//--- verilog/dshi_device.sv
// device end: four-wire and two-wire register access slave
// Notes on behaviour
// RULE_01: select high enables two-wire, resets four-wire
// RULE_02: four-wire samples rising, drives falling
// RULE_03: four-wire frame: address, command, data byte
// RULE_04: write at 24th rising edge, extra ignored
// RULE_05: master reselects before every further write
// RULE_06: early deselect aborts, no register update
// RULE_07: read fetch at 16th edge, msb next
// RULE_08: normal read shifts zeros past 24 edges
// RULE_09: queue burst: read header, then 24-bit words
// RULE_10: sample: tag plus top bits, then lower bytes
// RULE_11: two-wire open-drain data, clock input only
// RULE_12: stop recognised unless in start's high pulse
// RULE_13: seven-bit address, lowest bit from pin
// RULE_14: acknowledge each received byte, ninth pulse
// RULE_15: first byte loads pointer, writes auto-increment
// RULE_16: pointer holds at the queue port
// RULE_17: plain read after start begins at zero
// RULE_18: read after stop restarts at zero
// RULE_19: pointer preset then repeated start read
// RULE_20: master acks all but last, then stop
// RULE_21: master retries after missing acknowledge
// RULE_22: read command recognised by parameter mask
`timescale 1ns/1ps
`default_nettype none
module dshi_device
  import dshi_pkg::*;
#(
  parameter logic [7:0] RD_MASK = SPI_CMD_RD
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  dshi_if.dev              bus,
  output logic [7:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        q_valid,
  input  wire logic [23:0] q_data,
  output logic             q_ready
);
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_PTR, D_WR, D_RD} dshi_dst_t;

  // pins: select, cs/address, sclk, mosi, scl, sda
  logic [5:0] s1_q, s2_q, p_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= 6'h13;
      s2_q <= 6'h13;
      p_q  <= 6'h13;
    end else begin
      s1_q <= {bus.interface_select, bus.select_or_address_pin, bus.sclk, bus.mosi, bus.scl, bus.sda};
      s2_q <= s1_q;
      p_q  <= s2_q;
    end
  end

  logic i2c_on, spi_on, sck_r, sck_f;
  assign i2c_on = s2_q[5];
  assign spi_on = !s2_q[5] && !s2_q[4]; // [RULE_01]
  assign sck_r  = spi_on && s2_q[3] && !p_q[3];
  assign sck_f  = spi_on && !s2_q[3] && p_q[3];

  // two-entry buffer between sample queue and burst reads
  logic [23:0] bm_q [2];
  logic        wp_q, rp_q, rdy_q, push, pop;
  logic [1:0]  n_q, n_d;
  assign push = q_valid && rdy_q;
  assign n_d  = n_q + {1'b0, push} - {1'b0, pop};
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bm_q[0] <= 24'h0;
      bm_q[1] <= 24'h0;
      wp_q    <= 1'b0;
      rp_q    <= 1'b0;
      n_q     <= 2'h0;
      rdy_q   <= 1'b0;
    end else begin
      if (push) begin
        bm_q[wp_q] <= q_data;
        wp_q       <= !wp_q;
      end
      if (pop)
        rp_q <= !rp_q;
      n_q   <= n_d;
      rdy_q <= (n_d != 2'h2);
    end
  end

  // four-wire slave
  logic [4:0]  cnt_q, wc_q, cnt_n;
  logic [23:0] rx_q, rx_n, tx_q;
  logic        burst_q, miso_q, is_rd, spi_rd_ev, spi_wr_ev, load_word;
  assign cnt_n     = cnt_q + 5'h01;
  assign rx_n      = {rx_q[22:0], s2_q[2]};
  assign is_rd     = (rx_n[7:0] & RD_MASK) != 8'h00; // [RULE_22]
  assign spi_rd_ev = sck_r && cnt_n == SPI_RD_EDGE && is_rd && rx_n[15:8] != QUEUE_PORT; // [RULE_07]
  assign spi_wr_ev = sck_r && cnt_n == SPI_WR_EDGE && !burst_q
                     && (rx_n[15:8] & RD_MASK) == 8'h00; // [RULE_04] [RULE_03]
  assign load_word = sck_r && ((cnt_n == SPI_RD_EDGE && is_rd && rx_n[15:8] == QUEUE_PORT)
                     || (burst_q && wc_q == SPI_WORD_LAST)); // [RULE_09]
  // an empty buffer sends zeros rather than stalling the host's clock
  assign pop       = load_word && n_q != 2'h0;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q   <= 5'h00;
      wc_q    <= 5'h00;
      rx_q    <= 24'h0;
      burst_q <= 1'b0;
    end else if (!spi_on) begin
      cnt_q   <= 5'h00; // [RULE_06]
      wc_q    <= 5'h00;
      burst_q <= 1'b0;
    end else if (sck_r) begin
      rx_q <= rx_n; // [RULE_02]
      if (cnt_q != SPI_WR_EDGE)
        cnt_q <= cnt_n; // [RULE_04]
      if (load_word)
        burst_q <= 1'b1;
      if (burst_q)
        wc_q <= (wc_q == SPI_WORD_LAST) ? 5'h00 : wc_q + 5'h01;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_q   <= 24'h0;
      miso_q <= 1'b0;
    end else if (!spi_on) begin
      tx_q   <= 24'h0;
      miso_q <= 1'b0; // [RULE_01]
    end else if (load_word) begin
      tx_q <= pop ? bm_q[rp_q] : 24'h0; // [RULE_10]
    end else if (reg_rd && !i2c_on) begin
      tx_q <= {reg_rdata, 16'h0000};
    end else if (sck_f) begin
      miso_q <= tx_q[23]; // [RULE_02] [RULE_07]
      tx_q   <= {tx_q[22:0], 1'b0}; // [RULE_08]
    end
  end

  // two-wire slave
  dshi_dst_t  st_q;
  logic [3:0] bc_q;
  logic [7:0] sh_q, ptr_q, ptr_inc, i2c_tx_q;
  logic       rw_q, preset_q, busy_q, sthi_q, oe_q, nak_q;
  logic       scl_r, scl_f, start_ev, stop_ev, match, i2c_wr_ev, i2c_rd_ev;
  assign scl_r     = i2c_on && s2_q[1] && !p_q[1];
  assign scl_f     = i2c_on && !s2_q[1] && p_q[1];
  assign start_ev  = i2c_on && s2_q[1] && p_q[1] && p_q[0] && !s2_q[0];
  assign stop_ev   = i2c_on && s2_q[1] && p_q[1] && !p_q[0] && s2_q[0] && !sthi_q; // [RULE_12]
  assign match     = sh_q[7:1] == {I2C_ADDR_HI, s2_q[4]}; // [RULE_13]
  assign ptr_inc   = (ptr_q == QUEUE_PORT) ? ptr_q : ptr_q + 8'h01; // [RULE_16]
  assign i2c_wr_ev = scl_f && st_q == D_WR && bc_q == I2C_LAST_BIT;
  assign i2c_rd_ev = scl_f && bc_q == I2C_LAST_BIT
                     && ((st_q == D_ADDR && match && sh_q[0]) || st_q == D_RD);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= D_IDLE;
      bc_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= PTR_RESET;
      i2c_tx_q <= 8'h00;
      rw_q <= 1'b0;
      preset_q <= 1'b0;
      busy_q <= 1'b0;
      sthi_q <= 1'b0;
      oe_q <= 1'b0;
      nak_q <= 1'b0;
    end else if (!i2c_on) begin
      st_q <= D_IDLE; // [RULE_01]
      bc_q <= 4'h0;
      ptr_q <= PTR_RESET;
      preset_q <= 1'b0;
      busy_q <= 1'b0;
      sthi_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (start_ev) begin
      st_q <= D_ADDR;
      bc_q <= 4'h0;
      oe_q <= 1'b0;
      sthi_q <= 1'b1;
      busy_q <= 1'b1;
      if (!busy_q)
        preset_q <= 1'b0; // [RULE_17]
    end else if (stop_ev) begin
      st_q <= D_IDLE;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      preset_q <= 1'b0; // [RULE_18]
    end else begin
      if (scl_f)
        sthi_q <= 1'b0;
      if (reg_rd)
        i2c_tx_q <= reg_rdata;
      if (scl_r && st_q != D_IDLE) begin
        if (bc_q != I2C_ACK_BIT)
          sh_q <= {sh_q[6:0], s2_q[0]};
        else if (st_q == D_RD)
          nak_q <= s2_q[0];
      end
      // the fall that ends a start's high pulse carries no bit
      if (scl_f && st_q != D_IDLE && !sthi_q) begin
        bc_q <= (bc_q == I2C_ACK_BIT) ? 4'h0 : bc_q + 4'h1;
        case (st_q)
          D_ADDR: begin
            if (bc_q == I2C_LAST_BIT) begin
              if (match) begin
                oe_q <= 1'b1; // [RULE_14]
                rw_q <= sh_q[0];
                if (sh_q[0] && !preset_q)
                  ptr_q <= PTR_RESET; // [RULE_17]
              end else begin
                st_q <= D_IDLE;
              end
            end else if (bc_q == I2C_ACK_BIT) begin
              st_q <= rw_q ? D_RD : D_PTR;
              oe_q <= rw_q && !i2c_tx_q[7]; // [RULE_19]
              if (rw_q)
                i2c_tx_q <= {i2c_tx_q[6:0], 1'b0};
            end
          end
          D_PTR: begin
            if (bc_q == I2C_LAST_BIT) begin
              ptr_q <= sh_q; // [RULE_15]
              preset_q <= 1'b1;
              oe_q <= 1'b1; // [RULE_14]
            end else if (bc_q == I2C_ACK_BIT) begin
              oe_q <= 1'b0;
              st_q <= D_WR;
            end
          end
          D_WR: begin
            if (bc_q == I2C_LAST_BIT) begin
              oe_q <= 1'b1; // [RULE_14]
              ptr_q <= ptr_inc; // [RULE_15] [RULE_16]
            end else if (bc_q == I2C_ACK_BIT) begin
              oe_q <= 1'b0;
            end
          end
          D_RD: begin
            if (bc_q == I2C_LAST_BIT) begin
              oe_q <= 1'b0;
              ptr_q <= ptr_inc; // [RULE_17] [RULE_16]
            end else if (bc_q == I2C_ACK_BIT && nak_q) begin
              st_q <= D_IDLE;
              oe_q <= 1'b0;
            end else begin
              oe_q <= !i2c_tx_q[7]; // [RULE_11]
              i2c_tx_q <= {i2c_tx_q[6:0], 1'b0};
            end
          end
          default: st_q <= D_IDLE;
        endcase
      end
    end
  end

  // register port shared by both engines; only one is out of reset
  logic [7:0] ra_q, rw_data_q;
  logic       rwr_q, rrd_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ra_q <= 8'h00;
      rw_data_q <= 8'h00;
      rwr_q <= 1'b0;
      rrd_q <= 1'b0;
    end else begin
      rwr_q <= spi_wr_ev || i2c_wr_ev;
      rrd_q <= spi_rd_ev || i2c_rd_ev;
      if (spi_wr_ev || spi_rd_ev) begin
        ra_q <= spi_wr_ev ? rx_n[23:16] : rx_n[15:8];
        rw_data_q <= rx_n[7:0];
      end else if (i2c_wr_ev) begin
        ra_q <= ptr_q;
        rw_data_q <= sh_q;
      end else if (i2c_rd_ev) begin
        ra_q <= (st_q == D_ADDR) ? (preset_q ? ptr_q : PTR_RESET) : ptr_inc;
      end
    end
  end

  assign reg_addr     = ra_q;
  assign reg_wdata    = rw_data_q;
  assign reg_wr       = rwr_q;
  assign reg_rd       = rrd_q;
  assign q_ready      = rdy_q;
  assign bus.miso     = miso_q;
  assign bus.sda_d_o  = 1'b0;
  assign bus.sda_d_oe = oe_q; // [RULE_11]
endmodule
`default_nettype wire

//--- verilog/dshi_host.sv
// host end: four-wire and two-wire master issuing register commands
`timescale 1ns/1ps
`default_nettype none
module dshi_host
  import dshi_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  dshi_if.host             bus,
  input  wire logic        cmd_valid,
  input  wire dshi_op_t    cmd_op,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [7:0]  cmd_data,
  input  wire logic [7:0]  cmd_count,
  input  wire logic        addr_bit,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [23:0]      rsp_data,
  output logic             done,
  output logic             err
);
  typedef enum logic [2:0] {H_IDLE, H_SPI, H_START, H_BIT, H_STOP, H_GAP} dshi_hst_t;

  logic [1:0] s1_q, s2_q; // miso, sda
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= 2'h1;
      s2_q <= 2'h1;
    end else begin
      s1_q <= {bus.miso, bus.sda};
      s2_q <= s1_q;
    end
  end

  dshi_hst_t   st_q;
  dshi_op_t    op_q;
  logic [4:0]  tq_q;
  logic [1:0]  ph_q, idx_q, tries_q;
  logic [12:0] cnt_q, tot_q;
  logic [4:0]  wc_q;
  logic [23:0] tx_q, rx_q, rx_n, rsp_q;
  logic [7:0]  left_q, nxt;
  logic [3:0]  b_q;
  logic        sel_q, csa_q, sclk_q, mosi_q, scl_q, low_q, rxm_q, ack_q, retry_q;
  logic        rdy_q, rv_q, done_q, err_q, tick, i2c_op, accept;

  assign i2c_op = op_q == OP_I2C_WR || op_q == OP_I2C_RD;
  assign tick   = tq_q == 5'h00;
  assign accept = cmd_valid && rdy_q;
  assign rx_n   = {rx_q[22:0], s2_q[1]};

  always_comb begin
    case (idx_q)
      2'h0: nxt = {I2C_ADDR_HI, addr_bit, 1'b0};
      2'h1: nxt = cmd_addr;
      default: nxt = (op_q == OP_I2C_WR) ? cmd_data : {I2C_ADDR_HI, addr_bit, 1'b1};
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      tq_q <= 5'h00;
    else if (st_q == H_IDLE || tick)
      tq_q <= i2c_op ? 5'(I2C_QUARTER - 1) : 5'(SPI_HALF - 1);
    else
      tq_q <= tq_q - 5'h01;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= H_IDLE;
      op_q <= OP_SPI_WR;
      ph_q <= 2'h0;
      idx_q <= 2'h0;
      tries_q <= 2'h0;
      cnt_q <= 13'h0;
      tot_q <= 13'h0;
      wc_q <= 5'h00;
      tx_q <= 24'h0;
      rx_q <= 24'h0;
      rsp_q <= 24'h0;
      left_q <= 8'h00;
      b_q <= 4'h0;
      sel_q <= 1'b0;
      csa_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      scl_q <= 1'b1;
      low_q <= 1'b0;
      rxm_q <= 1'b0;
      ack_q <= 1'b0;
      retry_q <= 1'b0;
      rdy_q <= 1'b0;
      rv_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rv_q <= 1'b0;
      done_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          rdy_q <= !accept;
          if (accept) begin
            op_q <= cmd_op;
            ph_q <= 2'h0;
            cnt_q <= 13'h0;
            wc_q <= 5'h00;
            idx_q <= 2'h0;
            tries_q <= 2'h0;
            rxm_q <= 1'b0;
            err_q <= 1'b0;
            left_q <= (cmd_count == 8'h00) ? 8'h01 : cmd_count;
            tot_q <= (cmd_op == OP_SPI_BURST) ? 13'(16 + 24 * cmd_count) : 13'(SPI_WR_EDGE);
            tx_q <= {cmd_addr, (cmd_op == OP_SPI_WR) ? SPI_CMD_WR : SPI_CMD_RD, cmd_data}; // [RULE_03] [RULE_22]
            mosi_q <= cmd_addr[7];
            if (cmd_op == OP_I2C_WR || cmd_op == OP_I2C_RD) begin
              sel_q <= 1'b1; // [RULE_01]
              csa_q <= addr_bit; // [RULE_13]
              st_q <= H_START;
            end else begin
              sel_q <= 1'b0;
              csa_q <= 1'b0;
              st_q <= H_SPI;
            end
          end
        end
        H_SPI: if (tick) begin
          ph_q <= {1'b0, !ph_q[0]};
          if (!ph_q[0]) begin
            sclk_q <= 1'b1;
            rx_q <= rx_n; // [RULE_02] [RULE_07]
            cnt_q <= cnt_q + 13'h1;
            if (cnt_q >= 13'(SPI_RD_EDGE) && op_q != OP_SPI_WR) begin
              if (wc_q == ((op_q == OP_SPI_RD) ? SPI_BYTE_LAST : SPI_WORD_LAST)) begin
                wc_q <= 5'h00;
                rv_q <= 1'b1; // [RULE_09] [RULE_10]
                rsp_q <= (op_q == OP_SPI_RD) ? {16'h0000, rx_n[7:0]} : rx_n;
              end else begin
                wc_q <= wc_q + 5'h01;
              end
            end
          end else begin
            sclk_q <= 1'b0;
            if (cnt_q == tot_q) begin
              csa_q <= 1'b1; // [RULE_05]
              st_q <= H_GAP;
              done_q <= 1'b1;
            end else begin
              mosi_q <= tx_q[22]; // [RULE_02]
              tx_q <= {tx_q[22:0], 1'b0};
            end
          end
        end
        H_START: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: low_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: low_q <= 1'b1;
            default: begin
              scl_q <= 1'b0;
              st_q <= H_BIT;
              b_q <= 4'h0;
              tx_q <= {nxt, 16'h0000};
            end
          endcase
        end
        H_BIT: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: low_q <= (b_q == I2C_ACK_BIT) ? (rxm_q && left_q != 8'h01) : (!rxm_q && !tx_q[23]); // [RULE_20]
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (b_q != I2C_ACK_BIT)
                rx_q <= {rx_q[22:0], s2_q[0]};
              else
                ack_q <= !s2_q[0];
            end
            default: begin
              scl_q <= 1'b0;
              if (b_q != I2C_ACK_BIT) begin
                b_q <= b_q + 4'h1;
                tx_q <= {tx_q[22:0], 1'b0};
              end else begin
                b_q <= 4'h0;
                if (!rxm_q && !ack_q) begin
                  retry_q <= tries_q != RETRY_MAX; // [RULE_21]
                  err_q <= tries_q == RETRY_MAX;
                  st_q <= H_STOP;
                end else if (rxm_q) begin
                  rv_q <= 1'b1;
                  rsp_q <= {16'h0000, rx_q[7:0]};
                  left_q <= left_q - 8'h01;
                  if (left_q == 8'h01)
                    st_q <= H_STOP; // [RULE_20]
                end else if (idx_q == 2'h1 && op_q == OP_I2C_RD) begin
                  idx_q <= 2'h2;
                  st_q <= H_START; // [RULE_19]
                end else if (idx_q == 2'h2) begin
                  if (op_q == OP_I2C_WR)
                    st_q <= H_STOP;
                  else
                    rxm_q <= 1'b1;
                end else begin
                  idx_q <= idx_q + 2'h1;
                  tx_q <= {(idx_q == 2'h0) ? cmd_addr : cmd_data, 16'h0000};
                end
              end
            end
          endcase
        end
        H_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: low_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: low_q <= 1'b0; // [RULE_12]
            default: begin
              if (retry_q) begin
                retry_q <= 1'b0;
                tries_q <= tries_q + 2'h1;
                idx_q <= 2'h0;
                rxm_q <= 1'b0;
                st_q <= H_START;
              end else begin
                done_q <= 1'b1;
                st_q <= H_GAP;
              end
            end
          endcase
        end
        H_GAP: if (tick) begin
          st_q <= H_IDLE;
          rdy_q <= 1'b1;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign cmd_ready                 = rdy_q;
  assign rsp_valid                 = rv_q;
  assign rsp_data                  = rsp_q;
  assign done                      = done_q;
  assign err                       = err_q;
  assign bus.interface_select      = sel_q;
  assign bus.select_or_address_pin = csa_q;
  assign bus.sclk                  = sclk_q;
  assign bus.mosi                  = mosi_q;
  assign bus.scl                   = scl_q;
  assign bus.sda_h_o               = 1'b0;
  assign bus.sda_h_oe              = low_q;
endmodule
`default_nettype wire
